// >>> logic/ebiu_defines.svh
`ifndef EBIU_DEFINES_SVH
`define EBIU_DEFINES_SVH

`define EBIU_OFS_CTRL       8'h00
`define EBIU_OFS_STATUS     8'h04
`define EBIU_OFS_MASK       8'h08
`define EBIU_OFS_STATE      8'h0c

`define EBIU_CTRL_DBLOCK4   0
`define EBIU_CTRL_DMA_EARLY 1
`define EBIU_CTRL_PIN3_IO   2
`define EBIU_CTRL_PIN2_EXT  3
`define EBIU_CTRL_IO_RD     4
`define EBIU_CTRL_IO_WR     5
`define EBIU_CTRL_EXT_RD    6
`define EBIU_CTRL_EXT_WR    7
`define EBIU_CTRL_MS_RD     8
`define EBIU_CTRL_MS_WR     9
`define EBIU_CTRL_RST       32'h0000_0300

`define EBIU_EV_FAULT       0
`define EBIU_EV_GRANT       1
`define EBIU_EV_DONE        2
`define EBIU_EV_BITS        3

`define EBIU_RESP_OKAY      2'h0
`define EBIU_RESP_SLVERR    2'h2

`define EBIU_MEM_WAIT       4'h1

`endif

// >>> logic/ebiu_pkg.sv
package ebiu_pkg;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_ADDR    = 3'h1,
    S_DATA    = 3'h3,
    S_FLOAT   = 3'h2,
    S_GRANT   = 3'h6,
    S_RECLAIM = 3'h7
  } ebiu_dev_state_type;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_WAIT = 2'h1,
    M_GAP  = 2'h3
  } ebiu_mem_state_type;

endpackage : ebiu_pkg

// >>> logic/ebiu_if.sv
`timescale 1ns/1ns
interface ebiu_if;
  logic        system_reference_clock_out;
  logic        addr_latch;
  logic        read_ind_n;
  logic        write_ind_n;
  logic        burst_near_hint_n;
  logic        last_datum_n;
  logic        memory_datum_strobe_n;
  logic        ctl_oe;
  logic        external_master_grant;
  logic        external_master_request;
  logic        ack_n;
  logic        read_buffer_capture_enable_n;
  logic        transaction_fault_input;
  logic [31:0] ad_dev_out;
  logic        ad_dev_oe;
  logic [31:0] ad_mem_out;
  logic        ad_mem_oe;
  logic [31:0] ad;
  logic        pin3_out;
  logic        pin3_oe;
  logic        pin3_ext;
  logic        sync_condition_input_three;
  logic        pin2_out;
  logic        pin2_oe;
  logic        pin2_ext;
  logic        sync_condition_input_two;

  // Wire resolution; an undriven bus reads as zero
  assign ad = ad_dev_oe ? ad_dev_out : (ad_mem_oe ? ad_mem_out : 32'h0);
  assign sync_condition_input_three = pin3_oe ? pin3_out : pin3_ext;
  assign sync_condition_input_two   = pin2_oe ? pin2_out : pin2_ext;

  modport dev (
    output system_reference_clock_out, addr_latch, read_ind_n, write_ind_n,
    output burst_near_hint_n, last_datum_n, memory_datum_strobe_n, ctl_oe,
    output external_master_grant, ad_dev_out, ad_dev_oe, pin3_out, pin3_oe,
    output pin2_out, pin2_oe,
    input  external_master_request, ack_n, read_buffer_capture_enable_n,
    input  transaction_fault_input, ad, sync_condition_input_three,
    input  sync_condition_input_two
  );

  modport mem (
    input  system_reference_clock_out, addr_latch, read_ind_n, write_ind_n,
    input  burst_near_hint_n, last_datum_n, memory_datum_strobe_n, ctl_oe,
    input  external_master_grant, ad,
    output external_master_request, ack_n, read_buffer_capture_enable_n,
    output transaction_fault_input, ad_mem_out, ad_mem_oe, pin3_ext, pin2_ext
  );
endinterface : ebiu_if

// >>> logic/ebiu_sync.sv
`timescale 1ns/1ns
module ebiu_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : ebiu_sync

// >>> logic/ebiu_device.sv
// Summary of operation
// - Burst read asks for four contiguous words
// - Burst on instruction-miss reads; data-miss reads only when option set
// - Near hint on same-page back-to-back writes
// - Separate read and write indication outputs
// - Write acknowledge advances beat or ends
// - Read acknowledge releases data to core
// - Capture enable loads bus into read buffer
// - Drive reference clock of bus state machine
// - Request floats bus, negation returns it
// - Grant only after drivers are released
// - Early grant drop reclaims, await request drop
// - Condition three synchronised in branch mode
// - Condition two synchronised in branch mode
// - I/O strobe from second transfer cycle
// - Extended enable held half cycle longer
// - Memory strobe pulses once per datum
// - Last datum after next-to-last enable
// - Fault sampled only in transfers
`timescale 1ns/1ns
`include "ebiu_defines.svh"
module ebiu_device (
  input  wire logic         mclk,
  input  wire logic         nrst,
  ebiu_if.dev               bus,
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  output logic              irq,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire logic         req_write,
  input  wire logic [31:0]  req_addr,
  input  wire logic [127:0] req_wdata,
  input  wire logic [1:0]   req_beats,
  input  wire logic         req_imiss,
  input  wire logic         req_dmiss,
  output logic              rsp_valid,
  output logic              rsp_fault,
  output logic [127:0]      rsp_rdata,
  output logic              coprocessor_condition_three,
  output logic              coprocessor_condition_two
);
  import ebiu_pkg::*;

  ebiu_dev_state_type state;
  ebiu_dev_state_type next_state;
  logic        phase;
  logic        tick;
  logic        accept;
  logic        is_read;
  logic        next_read;
  logic [2:0]  beat;
  logic [2:0]  next_beat;
  logic [1:0]  beats_m1;
  logic [1:0]  next_beats_m1;
  logic        take;
  logic        done;
  logic        fault;
  logic        next_xfer;
  logic        prev_write;
  logic [23:0] prev_page;
  logic [31:0] addr;
  logic [31:0] wbuf [0:3];
  logic [31:0] rbuf [0:3];
  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [`EBIU_EV_BITS-1:0] status;
  logic [`EBIU_EV_BITS-1:0] events;
  logic [1:0]  cond_sync;
  logic        wr_fire;
  logic        ar_fire;
  logic [7:0]  aw_hold;
  logic [31:0] w_hold;
  logic [3:0]  s_hold;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return old;
  endfunction : merge

  function automatic logic sel(input logic rd, input logic rd_en, input logic wr_en);
    return rd ? rd_en : wr_en;
  endfunction : sel

  // Bus runs at half mclk, so one mclk is half a system cycle
  assign tick   = phase;
  assign accept = req_valid && req_ready;
  assign take   = is_read ? !bus.read_buffer_capture_enable_n : !bus.ack_n;
  assign done   = !bus.ack_n && ((beat + {2'h0, take}) > {1'b0, beats_m1});
  assign fault  = (state == S_DATA) && bus.transaction_fault_input;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase                          <= 1'b0;
      bus.system_reference_clock_out <= 1'b0;
    end else begin
      phase                          <= ~phase;
      bus.system_reference_clock_out <= ~phase;
    end
  end

  always_comb begin
    next_state    = state;
    next_read     = is_read;
    next_beat     = beat;
    next_beats_m1 = beats_m1;
    unique case (state)
      S_IDLE: begin
        if (accept) begin
          next_state    = S_ADDR;
          next_read     = !req_write;
          next_beat     = 3'h0;
          next_beats_m1 = req_write ? req_beats :
                          ((req_imiss || (req_dmiss && ctrl[`EBIU_CTRL_DBLOCK4])) ?
                           2'h3 : 2'h0);
        end else if (bus.external_master_request) begin
          next_state = S_FLOAT;
        end
      end
      S_ADDR: next_state = S_DATA;
      S_DATA: begin
        next_beat = beat + {2'h0, take};
        if (done || fault) begin
          next_state = S_IDLE;
        end
      end
      S_FLOAT: next_state = S_GRANT;
      S_GRANT: begin
        if (!bus.external_master_request) begin
          next_state = S_IDLE;
        end else if (ctrl[`EBIU_CTRL_DMA_EARLY] && req_valid) begin
          next_state = S_RECLAIM;
        end
      end
      S_RECLAIM: begin
        if (!bus.external_master_request) begin
          next_state = S_IDLE;
        end
      end
    endcase
  end

  assign next_xfer = (next_state == S_ADDR) || (next_state == S_DATA);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state    <= S_IDLE;
      is_read  <= 1'b0;
      beat     <= 3'h0;
      beats_m1 <= 2'h0;
    end else if (tick) begin
      state    <= next_state;
      is_read  <= next_read;
      beat     <= next_beat;
      beats_m1 <= next_beats_m1;
    end
  end

  // Ready opens only for the tick cycle so a request lines up with the bus clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= !tick && (state == S_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr       <= 32'h0;
      prev_write <= 1'b0;
      prev_page  <= 24'h0;
      for (int i = 0; i < 4; i++) begin
        wbuf[i] <= 32'h0;
        rbuf[i] <= 32'h0;
      end
    end else if (tick) begin
      if (state == S_IDLE && accept) begin
        addr       <= req_addr;
        prev_write <= req_write;
        prev_page  <= req_addr[31:8];
        for (int i = 0; i < 4; i++) begin
          wbuf[i] <= req_wdata[i*32 +: 32];
        end
      end else if (state == S_FLOAT) begin
        prev_write <= 1'b0;
      end
      if (state == S_DATA && is_read && take) begin
        rbuf[beat[1:0]] <= bus.ad;
      end
    end
  end

  // Pin outputs change on the tick edge from the state they enter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus.addr_latch            <= 1'b0;
      bus.read_ind_n            <= 1'b1;
      bus.write_ind_n           <= 1'b1;
      bus.burst_near_hint_n     <= 1'b1;
      bus.last_datum_n          <= 1'b1;
      bus.ctl_oe                <= 1'b1;
      bus.external_master_grant <= 1'b0;
      bus.ad_dev_oe             <= 1'b0;
      bus.ad_dev_out            <= 32'h0;
      bus.pin3_out              <= 1'b1;
      bus.pin3_oe               <= 1'b0;
      bus.pin2_oe               <= 1'b0;
    end else if (tick) begin
      bus.addr_latch  <= next_state == S_ADDR;
      bus.read_ind_n  <= !(next_xfer && next_read);
      bus.write_ind_n <= !(next_xfer && !next_read);
      if (state == S_IDLE && accept) begin
        bus.burst_near_hint_n <= req_write ?
          !(prev_write && prev_page == req_addr[31:8]) :
          !(req_imiss || (req_dmiss && ctrl[`EBIU_CTRL_DBLOCK4]));
      end else if (!next_xfer) begin
        bus.burst_near_hint_n <= 1'b1;
      end
      bus.last_datum_n <= !(next_xfer && next_beat >= {1'b0, next_beats_m1});
      bus.ctl_oe       <= !(next_state inside {S_FLOAT, S_GRANT, S_RECLAIM});
      bus.external_master_grant <= next_state == S_GRANT;
      bus.ad_dev_oe  <= (next_state == S_ADDR) || (next_state == S_DATA && !next_read);
      bus.ad_dev_out <= (next_state == S_ADDR) ? (accept ? req_addr : addr) :
                        ((state == S_ADDR) ? wbuf[0] : wbuf[next_beat[1:0]]);
      bus.pin3_out <= !(next_state == S_DATA && sel(next_read, ctrl[`EBIU_CTRL_IO_RD],
                        ctrl[`EBIU_CTRL_IO_WR]));
      bus.pin3_oe  <= ctrl[`EBIU_CTRL_PIN3_IO] && !(next_state inside {S_FLOAT, S_GRANT,
                        S_RECLAIM});
      bus.pin2_oe  <= ctrl[`EBIU_CTRL_PIN2_EXT] && !(next_state inside {S_FLOAT, S_GRANT,
                        S_RECLAIM});
    end
  end

  // Strobes that move on the half-cycle edge as well
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus.pin2_out              <= 1'b1;
      bus.memory_datum_strobe_n <= 1'b1;
    end else if (tick) begin
      if (next_xfer && sel(next_read, ctrl[`EBIU_CTRL_EXT_RD], ctrl[`EBIU_CTRL_EXT_WR])) begin
        bus.pin2_out <= 1'b0;
      end
      // A fault ends the transfer without a datum, so the strobe must close too
      if (state == S_DATA && (take || done || fault)) begin
        bus.memory_datum_strobe_n <= 1'b1;
      end
    end else begin
      if (!(state inside {S_ADDR, S_DATA})) begin
        bus.pin2_out <= 1'b1;
      end
      bus.memory_datum_strobe_n <= !(state == S_DATA &&
        sel(is_read, ctrl[`EBIU_CTRL_MS_RD], ctrl[`EBIU_CTRL_MS_WR]));
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_fault <= 1'b0;
    end else begin
      rsp_valid <= tick && state == S_DATA && (done || fault);
      rsp_fault <= tick && fault && is_read;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_rsp
    assign rsp_rdata[g*32 +: 32] = rbuf[g];
  end

  ebiu_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({bus.sync_condition_input_three, bus.sync_condition_input_two}),
    .sync_out (cond_sync)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      coprocessor_condition_three <= 1'b0;
      coprocessor_condition_two   <= 1'b0;
    end else begin
      coprocessor_condition_three <= !ctrl[`EBIU_CTRL_PIN3_IO] && cond_sync[1];
      coprocessor_condition_two   <= !ctrl[`EBIU_CTRL_PIN2_EXT] && cond_sync[0];
    end
  end

  assign events[`EBIU_EV_FAULT] = tick && fault;
  assign events[`EBIU_EV_GRANT] = tick && state == S_FLOAT;
  assign events[`EBIU_EV_DONE]  = tick && state == S_DATA && done;
  assign wr_fire = !awready && !wready && !bvalid;
  assign ar_fire = arvalid && arready;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `EBIU_RESP_OKAY;
      aw_hold <= 8'h0;
      w_hold  <= 32'h0;
      s_hold  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold <= wdata;
        s_hold <= wstrb;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (aw_hold == `EBIU_OFS_CTRL || aw_hold == `EBIU_OFS_MASK) ?
                  `EBIU_RESP_OKAY : `EBIU_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `EBIU_CTRL_RST;
      mask <= 32'h0;
    end else if (wr_fire) begin
      if (aw_hold == `EBIU_OFS_CTRL) begin
        ctrl <= merge(ctrl, w_hold, s_hold);
      end
      if (aw_hold == `EBIU_OFS_MASK) begin
        mask <= merge(mask, w_hold, s_hold);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `EBIU_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `EBIU_RESP_OKAY;
        unique case (araddr)
          `EBIU_OFS_CTRL:   rdata <= ctrl;
          `EBIU_OFS_STATUS: rdata <= {29'h0, status};
          `EBIU_OFS_MASK:   rdata <= mask;
          `EBIU_OFS_STATE:  rdata <= {24'h0, coprocessor_condition_three,
                                      coprocessor_condition_two, 3'h0, state};
          default: begin
            rdata <= 32'h0;
            rresp <= `EBIU_RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // A read clears the sticky bits, but an event in the same cycle survives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= ((ar_fire && araddr == `EBIU_OFS_STATUS) ? '0 : status) | events;
      irq    <= |(status & mask[`EBIU_EV_BITS-1:0]);
    end
  end
endmodule : ebiu_device

// >>> logic/ebiu_mem_end.sv
`timescale 1ns/1ns
`include "ebiu_defines.svh"
module ebiu_mem_end #(
  parameter logic [3:0] WAIT = `EBIU_MEM_WAIT
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  ebiu_if.mem              bus,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        inject_fault,
  input  wire logic [1:0]  cond_level,
  input  wire logic        dma_request,
  output logic             dma_granted,
  output logic             dma_reclaim,
  output logic             wr_valid,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [31:0]      cur_addr
);
  import ebiu_pkg::*;

  ebiu_mem_state_type mstate;
  logic [3:0] cnt;
  logic       sys;
  logic       fire;
  logic       had_grant;

  // Acts only on the edges where the reference clock is high, as the device does
  assign sys  = bus.system_reference_clock_out;
  assign fire = sys && mstate == M_WAIT && cnt == 4'h0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mstate                           <= M_IDLE;
      cnt                              <= 4'h0;
      cur_addr                         <= 32'h0;
      bus.ack_n                        <= 1'b1;
      bus.read_buffer_capture_enable_n <= 1'b1;
      bus.transaction_fault_input      <= 1'b0;
      bus.ad_mem_oe                    <= 1'b0;
      bus.ad_mem_out                   <= 32'h0;
    end else if (sys) begin
      bus.ack_n                        <= 1'b1;
      bus.read_buffer_capture_enable_n <= 1'b1;
      bus.transaction_fault_input      <= 1'b0;
      bus.ad_mem_oe                    <= 1'b0;
      unique case (mstate)
        M_IDLE: begin
          if (bus.addr_latch) begin
            cur_addr <= bus.ad;
            cnt      <= WAIT;
            mstate   <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (bus.read_ind_n && bus.write_ind_n) begin
            mstate <= M_IDLE;
          end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else begin
            mstate <= M_GAP;
            cnt    <= WAIT;
            if (inject_fault) begin
              bus.transaction_fault_input <= 1'b1;
            end else if (!bus.read_ind_n) begin
              bus.ad_mem_out                   <= mem_rdata;
              bus.ad_mem_oe                    <= 1'b1;
              bus.read_buffer_capture_enable_n <= 1'b0;
              bus.ack_n                        <= bus.last_datum_n;
            end else begin
              bus.ack_n <= 1'b0;
            end
          end
        end
        M_GAP: begin
          // One idle tick lets the last datum flag settle before the next beat
          mstate <= (bus.read_ind_n && bus.write_ind_n) ? M_IDLE : M_WAIT;
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_addr  <= 32'h0;
      wr_data  <= 32'h0;
    end else begin
      wr_valid <= fire && !inject_fault && !bus.write_ind_n;
      if (fire && !bus.write_ind_n) begin
        wr_addr <= cur_addr;
        wr_data <= bus.ad;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus.external_master_request <= 1'b0;
      had_grant                   <= 1'b0;
      dma_granted                 <= 1'b0;
      dma_reclaim                 <= 1'b0;
      bus.pin3_ext                <= 1'b0;
      bus.pin2_ext                <= 1'b0;
    end else begin
      bus.pin3_ext <= cond_level[1];
      bus.pin2_ext <= cond_level[0];
      if (sys) begin
        dma_granted <= bus.external_master_grant;
        if (!dma_request) begin
          had_grant   <= 1'b0;
          dma_reclaim <= 1'b0;
        end else if (bus.external_master_grant) begin
          had_grant <= 1'b1;
        end else if (had_grant) begin
          dma_reclaim <= 1'b1;
        end
        bus.external_master_request <= dma_request && !dma_reclaim &&
          !(had_grant && !bus.external_master_grant);
      end
    end
  end
endmodule : ebiu_mem_end

// >>> test/ebiu_sva.sv
`timescale 1ns/1ns
module ebiu_sva (
  input logic mclk,
  input logic nrst,
  input logic system_reference_clock_out,
  input logic addr_latch,
  input logic read_ind_n,
  input logic write_ind_n,
  input logic memory_datum_strobe_n,
  input logic ctl_oe,
  input logic external_master_grant,
  input logic external_master_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_excl; read_ind_n || write_ind_n; endproperty
  a_excl: assert property (p_excl) else $error("overlap");
  // Skip the release edge, where the clock output still holds its reset level
  property p_clk; $past(nrst) |-> $changed(system_reference_clock_out); endproperty
  a_clk: assert property (p_clk) else $error("clock stuck");
  property p_lat; $rose(addr_latch) |=> addr_latch ##1 !addr_latch; endproperty
  a_lat: assert property (p_lat) else $error("latch width");
  property p_dir; addr_latch |-> read_ind_n != write_ind_n; endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_strb; !memory_datum_strobe_n |-> !(read_ind_n && write_ind_n); endproperty
  a_strb: assert property (p_strb) else $error("stray strobe");
  property p_gnt; external_master_grant |-> !ctl_oe; endproperty
  a_gnt: assert property (p_gnt) else $error("grant driving");
  property p_req; $rose(external_master_grant) |-> external_master_request; endproperty
  a_req: assert property (p_req) else $error("grant unasked");
  property p_rel;
    external_master_grant && !external_master_request |-> ##[1:4] !external_master_grant;
  endproperty
  a_rel: assert property (p_rel) else $error("no return");
endmodule : ebiu_sva

// >>> test/ebiu_bench.sv
`timescale 1ns/1ns
module ebiu_bench;
  logic mclk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic req_valid = 0, req_write = 0, req_imiss = 0, req_dmiss = 0, inject_fault = 0;
  logic dma_request = 0, hint, flt, awready, wready, bvalid, arready, rvalid, irq;
  logic req_ready, rsp_valid, rsp_fault, dma_granted, dma_reclaim, wr_valid, io;
  logic coprocessor_condition_three, coprocessor_condition_two;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] req_beats = 0, cond_level = 0, bresp, rresp, rs;
  logic [31:0] wdata = 0, req_addr = 0, mem_rdata = 32'h1234_5678, rdata, wr_addr, wr_data;
  logic [31:0] cur_addr, wd, d;
  logic [127:0] req_wdata = {32'h4, 32'h3, 32'h2, 32'h1}, rsp_rdata;
  int fail_count = 0, samples_checked = 0, strobes = 0;
  ebiu_if bus ();
  ebiu_device i_ebiu_device (.*);
  ebiu_mem_end i_ebiu_mem_end (.*);
  ebiu_sva i_ebiu_sva (
    .mclk,
    .nrst,
    .system_reference_clock_out(bus.system_reference_clock_out),
    .addr_latch(bus.addr_latch),
    .read_ind_n(bus.read_ind_n),
    .write_ind_n(bus.write_ind_n),
    .memory_datum_strobe_n(bus.memory_datum_strobe_n),
    .ctl_oe(bus.ctl_oe),
    .external_master_grant(bus.external_master_grant),
    .external_master_request(bus.external_master_request)
  );
  always #10 mclk = ~mclk;
  always @(negedge bus.memory_datum_strobe_n) strobes++;
  always @(posedge mclk) begin
    if (bus.burst_near_hint_n === 1'b0) hint = 1;
    if (bus.sync_condition_input_three === 1'b0) io = 1;
    if (wr_valid === 1'b1) wd = wr_data;
  end
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Address and data may be taken on different edges; each is released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) aw_ok = 1;
      if (wready === 1'b1) w_ok = 1;
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
    end while (!aw_ok || !w_ok);
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 0;
    d = rdata;
    rs = rresp;
  endtask : rd
  task automatic xfer(input logic w, input logic [31:0] a, input logic [1:0] n, input logic i);
    hint = 0;
    io = 0;
    strobes = 0;
    req_write <= w;
    req_addr <= a;
    req_beats <= n;
    req_imiss <= i;
    req_valid <= 1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 0;
    do @(posedge mclk); while (rsp_valid !== 1'b1);
    flt = rsp_fault;
    repeat (4) @(posedge mclk);
  endtask : xfer
  task automatic t_regs;
    rd(8'h00);
    chk("ctrl", 32'h300, d);
    rd(8'h10);
    chk("unmapped", 2'h2, rs);
  endtask : t_regs
  task automatic t_bus;
    xfer(0, 32'h100, 0, 1);
    chk("burst", 1, hint);
    chk("strobes", 4, strobes);
    chk("rdata", {4{mem_rdata}}, rsp_rdata);
    xfer(0, 32'h120, 0, 0);
    chk("single", 0, hint);
    xfer(1, 32'h200, 0, 0);
    xfer(1, 32'h2fc, 1, 0);
    chk("near", 1, hint);
    chk("beats", 2, wd);
    xfer(1, 32'h300, 0, 0);
    chk("far", 0, hint);
  endtask : t_bus
  task automatic t_fault;
    inject_fault <= 1;
    xfer(0, 32'h400, 0, 0);
    inject_fault <= 0;
    chk("fault", 1, flt);
    chk("masked", 0, irq);
    wr(8'h08, 32'h1);
    // The level follows the new mask one edge after the write response
    @(posedge mclk);
    chk("irq", 1, irq);
    rd(8'h04);
    chk("status", 1, d[0]);
    rd(8'h04);
    chk("irq clr", 0, irq);
  endtask : t_fault
  task automatic t_dma;
    dma_request <= 1;
    do @(posedge mclk); while (dma_granted !== 1'b1);
    chk("float", 0, bus.ctl_oe);
    dma_request <= 0;
    xfer(0, 32'h500, 0, 0);
    chk("back", 1, strobes);
  endtask : t_dma
  task automatic t_modes;
    cond_level <= 2'h3;
    repeat (6) @(posedge mclk);
    chk("cond3", 1, coprocessor_condition_three);
    chk("cond2", 1, coprocessor_condition_two);
    wr(8'h00, 32'h317);
    req_dmiss <= 1;
    xfer(0, 32'h700, 0, 0);
    req_dmiss <= 0;
    chk("dmiss", 1, hint);
    chk("io", 1, io);
    chk("cond3 off", 0, coprocessor_condition_three);
    dma_request <= 1;
    do @(posedge mclk); while (dma_granted !== 1'b1);
    xfer(0, 32'h800, 0, 0);
    chk("reclaim", 1, dma_reclaim);
    dma_request <= 0;
  endtask : t_modes
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1;
    t_regs;
    t_bus;
    t_fault;
    t_dma;
    t_modes;
    print_verdict;
  end
  initial begin
    #1000000;
    fail_count++;
    print_verdict;
  end
endmodule : ebiu_bench
